// [hw/scd_delay.sv]
// file: start-up delay counter
`timescale 1ns/10ps
module scd_delay #(
  parameter int W = 24
) (
  input wire logic clk_sys_i,          // clock
  input wire logic rstn_i,             // async reset, active low
  input wire logic load_i,             // start a new count
  input wire logic [W-1:0] len_i,      // cycles to wait
  input wire logic tick_i,             // count enable edge
  output logic done_o                  // delay expired
);
  logic [W-1:0] cnt_ff, nxt_cnt;

  // count down on ticks; zero means done
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load_i) begin
      nxt_cnt = len_i;
    end else if (tick_i && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign done_o = (cnt_ff == '0) && !load_i;
endmodule

// [hw/scd_div_core.sv]
// file: glitch-free power-of-two clock enable generator
`timescale 1ns/10ps
module scd_div_core #(
  parameter int CNT_W = 8
) (
  input wire logic clk_sys_i,          // undivided source clock
  input wire logic rstn_i,             // async reset, active low
  input wire logic [3:0] div_i,        // requested division code
  output logic tick_o,                 // one-cycle divided clock edge
  output logic clk_div_o,              // divided clock level
  output logic [3:0] div_act_o         // code now in effect
);
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [3:0] act_ff, nxt_act;
  logic lvl_ff, nxt_lvl;

  function automatic logic [CNT_W-1:0] last_cnt(input logic [3:0] code);
    last_cnt = CNT_W'((9'h001 << code) - 9'h001);
  endfunction

  // count to the end of the period, adopt new code only at a period
  // boundary so no period is shorter than old or new
  always_comb begin
    nxt_cnt = cnt_ff + 1'b1;
    nxt_act = act_ff;
    nxt_lvl = lvl_ff;
    if (cnt_ff >= last_cnt(act_ff)) begin
      nxt_cnt = '0;
      nxt_act = div_i;
    end
    if (act_ff == 4'h0) begin
      nxt_lvl = 1'b1;
    end else begin
      nxt_lvl = (cnt_ff < (last_cnt(act_ff) >> 1)) || (cnt_ff >= last_cnt(act_ff));
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
      act_ff <= 4'h0;
      lvl_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      act_ff <= nxt_act;
      lvl_ff <= nxt_lvl;
    end
  end

  assign tick_o = (cnt_ff >= last_cnt(act_ff));
  // undivided: the source clock itself goes out, since a registered level cannot toggle every cycle;
  // the swap always lands on a high phase at a period end, so no runt pulse reaches the pin
  assign clk_div_o = (act_ff == 4'h0) ? clk_sys_i : lvl_ff;
  assign div_act_o = act_ff;
endmodule

// [hw/scd_pkg.sv]
// package: constants for the system clock divider and source block
package scd_pkg;
  // clock source select fuse codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_RSVD = 2'h1;
  localparam logic [1:0] SRC_RC = 2'h2;
  localparam logic [1:0] SRC_LP = 2'h3;
  // start-up fuse codes
  localparam logic [1:0] SUT_BOD = 2'h0;
  localparam logic [1:0] SUT_FAST = 2'h1;
  localparam logic [1:0] SUT_SLOW = 2'h2;
  localparam logic [1:0] SUT_RSVD = 2'h3;
  // register offsets (own map)
  localparam logic [1:0] OFS_OSC_TRIM = 2'h0;
  localparam logic [1:0] OFS_DIV_CTRL = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;
  // divider control fields
  localparam int UNLOCK_BIT = 7;
  localparam logic [3:0] DIV_RST_NODIV8 = 4'h0;
  localparam logic [3:0] DIV_RST_DIV8 = 4'h3;
  localparam logic [3:0] DIV_MAX_CODE = 4'h8;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int RESET_BASE_CK = 14;
  localparam int WAKE_CK = 6;
  localparam int SUT_FAST_MS = 4;
  localparam int SUT_SLOW_MS = 64;
  localparam int SUT_FAST_CYC = SUT_FAST_MS * CLK_MHZ * 1000;
  localparam int SUT_SLOW_CYC = SUT_SLOW_MS * CLK_MHZ * 1000;
endpackage

// [hw/scd_top.sv]
// file: system clock source, start-up delay, output buffer and divider
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module scd_top #(
  parameter logic [7:0] FACTORY_TRIM = 8'h80,              // arbitrary factory calibration
  parameter int FAST_CYC = scd_pkg::SUT_FAST_CYC,          // 4 ms in cycles
  parameter int SLOW_CYC = scd_pkg::SUT_SLOW_CYC,          // 64 ms in cycles
  parameter int DLY_W = 24                                 // delay counter width
) (
  input wire logic clk_sys_i,              // undivided system clock
  input wire logic rstn_i,                 // async reset, active low
  input wire logic ext_clock_in_pin_i,     // external clock pin level
  input wire logic clk_rc_i,               // calibrated oscillator level
  input wire logic clk_lp_i,               // low-power oscillator level
  input wire logic [1:0] clock_source_select_fuse_i, // source fuse
  input wire logic [1:0] startup_time_fuse_i,        // start-up fuse
  input wire logic clock_output_fuse_i,    // 1 = output fuse programmed
  input wire logic divide_by_eight_fuse_i, // 1 = fuse programmed
  input wire logic wake_i,                 // power-down wake request pulse
  input wire logic [1:0] addr_i,           // register address
  input wire logic [7:0] wdata_i,          // write data
  input wire logic wr_i,                   // write strobe
  input wire logic rd_i,                   // read strobe
  output logic [7:0] rdata_o,              // read data, cycle after rd
  output logic src_clk_o,                  // selected source clock level
  output logic clock_output_pin_o,         // clock output pin value
  output logic clock_output_pin_oe_o,      // clock output pin drive enable
  output logic clk_en_io_o,                // io domain clock enable
  output logic clk_en_adc_o,               // converter domain enable
  output logic clk_en_cpu_o,               // core domain enable
  output logic clk_en_flash_o,             // program memory domain enable
  output logic core_run_o,                 // start-up delay finished
  output logic [7:0] osc_trim_o            // trim code to oscillator
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b10
  } scd_st_t;

  scd_st_t st_ff, nxt_st;
  logic [7:0] trim_ff, nxt_trim;
  logic [3:0] div_ff, nxt_div;
  logic unlock_ff, nxt_unlock;
  logic [2:0] win_ff, nxt_win;
  logic [7:0] rdata_ff, nxt_rdata;
  logic init_ff, nxt_init;
  logic dly_load;
  logic [DLY_W-1:0] dly_len;
  logic dly_done;
  logic tick;
  logic clk_div;
  logic [3:0] div_act;
  logic wr_trim, wr_div;

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  // reserved code falls back to the rc oscillator
  always_comb begin
    unique case (clock_source_select_fuse_i)
      scd_pkg::SRC_EXT: src_clk_o = ext_clock_in_pin_i;
      scd_pkg::SRC_RC: src_clk_o = clk_rc_i;
      scd_pkg::SRC_LP: src_clk_o = clk_lp_i;
      scd_pkg::SRC_RSVD: src_clk_o = clk_rc_i;
    endcase
  end

  // ----------------------------------------
  // start-up delay
  // ----------------------------------------
  function automatic logic [DLY_W-1:0] reset_len(input logic [1:0] startup_time_fuse);
    logic [DLY_W-1:0] base;
    base = DLY_W'(scd_pkg::RESET_BASE_CK);
    unique case (startup_time_fuse)
      scd_pkg::SUT_BOD: reset_len = base;
      scd_pkg::SUT_FAST: reset_len = base + DLY_W'(FAST_CYC);
      scd_pkg::SUT_SLOW: reset_len = base + DLY_W'(SLOW_CYC);
      scd_pkg::SUT_RSVD: reset_len = base + DLY_W'(SLOW_CYC); // reserved: longest, safest
    endcase
  endfunction

  // delay counts in source cycles; the divider is not yet relevant
  always_comb begin
    nxt_st = st_ff;
    dly_load = 1'b0;
    dly_len = reset_len(startup_time_fuse_i);
    unique case (st_ff)
      ST_INIT: begin
        dly_load = 1'b1;
        nxt_st = ST_WAIT;
      end
      ST_WAIT: begin
        if (dly_done) begin
          nxt_st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wake_i) begin
          dly_load = 1'b1;
          dly_len = DLY_W'(scd_pkg::WAKE_CK);
          nxt_st = ST_WAIT;
        end
      end
      default: nxt_st = ST_INIT;
    endcase
  end

  scd_delay #(.W(DLY_W)) u_delay (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(dly_load),
    .len_i(dly_len),
    .tick_i(1'b1),
    .done_o(dly_done)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign wr_trim = wr_i && (addr_i == scd_pkg::OFS_OSC_TRIM);
  assign wr_div = wr_i && (addr_i == scd_pkg::OFS_DIV_CTRL);

  // fuse-dependent reset values are taken on the first clock after release,
  // since async reset may only load constants
  always_comb begin
    nxt_init = 1'b1;
    nxt_trim = trim_ff;
    nxt_div = div_ff;
    nxt_unlock = unlock_ff;
    nxt_win = win_ff;
    if (!init_ff) begin
      nxt_trim = FACTORY_TRIM;
      nxt_div = divide_by_eight_fuse_i ? scd_pkg::DIV_RST_DIV8 : scd_pkg::DIV_RST_NODIV8;
    end else begin
      if (wr_trim) begin
        nxt_trim = wdata_i;
      end
      // window counts divided-clock edges
      if (unlock_ff && tick) begin
        nxt_win = win_ff + 3'h1;
        if (win_ff + 3'h1 >= scd_pkg::UNLOCK_CYCLES) begin
          nxt_unlock = 1'b0;
        end
      end
      if (wr_div) begin
        if (unlock_ff && !wdata_i[scd_pkg::UNLOCK_BIT]) begin
          nxt_div = wdata_i[3:0];
          nxt_unlock = 1'b0;
        end else if (!unlock_ff && wdata_i == 8'h80) begin
          nxt_unlock = 1'b1;
          nxt_win = 3'h0;
        end
        // a repeat unlock write falls through untouched
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= ST_INIT;
      init_ff <= 1'b0;
      trim_ff <= 8'h00;
      div_ff <= 4'h0;
      unlock_ff <= 1'b0;
      win_ff <= 3'h0;
      rdata_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      init_ff <= nxt_init;
      trim_ff <= nxt_trim;
      div_ff <= nxt_div;
      unlock_ff <= nxt_unlock;
      win_ff <= nxt_win;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  // unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        scd_pkg::OFS_OSC_TRIM: nxt_rdata = trim_ff;
        scd_pkg::OFS_DIV_CTRL: nxt_rdata = {unlock_ff, 3'h0, div_ff};
        scd_pkg::OFS_STATUS: nxt_rdata = {3'h0, st_ff == ST_RUN, div_act};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // divider and clock outputs
  // ----------------------------------------
  // reserved codes saturate at the largest factor
  scd_div_core u_div (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .div_i((div_ff > scd_pkg::DIV_MAX_CODE) ? scd_pkg::DIV_MAX_CODE : div_ff),
    .tick_o(tick),
    .clk_div_o(clk_div),
    .div_act_o(div_act)
  );

  // one enable feeds every domain, gated by the start-up delay
  assign clk_en_io_o = tick && (st_ff == ST_RUN);
  assign clk_en_adc_o = tick && (st_ff == ST_RUN);
  assign clk_en_cpu_o = tick && (st_ff == ST_RUN);
  assign clk_en_flash_o = tick && (st_ff == ST_RUN);
  assign core_run_o = (st_ff == ST_RUN);
  // output pin runs also while the delay holds the core
  assign clock_output_pin_o = clock_output_fuse_i & clk_div;
  assign clock_output_pin_oe_o = clock_output_fuse_i;
  assign osc_trim_o = trim_ff;
  assign rdata_o = rdata_ff;
endmodule

// [sim/scd_ext_clk_model.sv]
// partner: external clock source driving the clock input pin
`timescale 1ns/10ps
module scd_ext_clk_model (
  input wire logic rstn_i, // device reset, active low
  input int half_i,        // requested half period in ns
  output logic clk_o       // clock pin level
);
  int half_ff = 7;
  initial clk_o = 1'b0;
  // free-running source; a new rate is adopted only while reset holds the device
  always begin
    #(half_ff) clk_o = ~clk_o;
    if (!rstn_i) half_ff = half_i;
  end
endmodule

// [sim/scd_top_sva.sv]
// checker: port assertions for the clock source and divider top
`timescale 1ns/10ps
module scd_top_sva (
  input wire logic clk_sys_i, // clock
  input wire logic rstn_i, // reset, active low
  input wire logic ext_clock_in_pin_i, // external pin
  input wire logic clk_lp_i, // low-power oscillator
  input wire logic [1:0] clock_source_select_fuse_i, // source fuse
  input wire logic clock_output_fuse_i, // output fuse
  input wire logic [1:0] addr_i, // address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [7:0] rdata_o, // read data
  input wire logic src_clk_o, // selected source
  input wire logic clock_output_pin_o, // output pin
  input wire logic clock_output_pin_oe_o, // output enable
  input wire logic clk_en_io_o, // io enable
  input wire logic clk_en_adc_o, // converter enable
  input wire logic clk_en_cpu_o, // core enable
  input wire logic clk_en_flash_o, // memory enable
  input wire logic core_run_o, // start-up done
  input wire logic [7:0] osc_trim_o // trim code
);
  logic [7:0] cyc_ff;
  logic [7:0] nxt_cyc;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // cycles since reset release, saturating so the start-up check never wraps
  always_comb nxt_cyc = (cyc_ff == 8'hff) ? cyc_ff : cyc_ff + 8'h01;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) cyc_ff <= 8'h00;
    else cyc_ff <= nxt_cyc;
  end
  a_oe_follows_fuse: assert property (clock_output_pin_oe_o == clock_output_fuse_i)
    else $error("clock pin enable differs from fuse");
  a_pin_quiet_unfused: assert property (!clock_output_fuse_i |-> !clock_output_pin_o)
    else $error("clock pin active without fuse");
  a_domains_same: assert property ({clk_en_io_o, clk_en_adc_o, clk_en_flash_o} == {3{clk_en_cpu_o}})
    else $error("domain enables differ");
  a_ext_source: assert property (clock_source_select_fuse_i == scd_pkg::SRC_EXT |-> src_clk_o == ext_clock_in_pin_i)
    else $error("external pin not selected");
  a_lp_source: assert property (clock_source_select_fuse_i == scd_pkg::SRC_LP |-> src_clk_o == clk_lp_i)
    else $error("low-power source not selected");
  a_enables_gated: assert property (!core_run_o |-> !clk_en_cpu_o)
    else $error("enable before start-up done");
  a_startup_min: assert property ($rose(core_run_o) |-> cyc_ff >= 8'h0e)
    else $error("start-up shorter than base delay");
  a_reserved_zero: assert property (rd_i && addr_i == scd_pkg::OFS_DIV_CTRL |=> rdata_o[6:4] == 3'h0)
    else $error("reserved bits read nonzero");
  a_trim_write: assert property (wr_i && addr_i == scd_pkg::OFS_OSC_TRIM |=> osc_trim_o == $past(wdata_i))
    else $error("trim write not applied");
endmodule
bind scd_top scd_top_sva scd_top_sva_inst (.clk_sys_i, .rstn_i, .ext_clock_in_pin_i, .clk_lp_i,
  .clock_source_select_fuse_i, .clock_output_fuse_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .src_clk_o,
  .clock_output_pin_o, .clock_output_pin_oe_o, .clk_en_io_o, .clk_en_adc_o, .clk_en_cpu_o, .clk_en_flash_o,
  .core_run_o, .osc_trim_o);

// [sim/system_clock_divider_and_source_tb.sv]
// testbench: registers, start-up and divider of the clock block
`timescale 1ns/10ps
module system_clock_divider_and_source_tb;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, ext_pin, clk_rc_i = 1'b0, clk_lp_i = 1'b0;
  logic [1:0] src_fuse = 2'h0, sut_fuse = 2'h0, addr_i = 2'h0;
  logic out_fuse = 1'b1, div8_fuse = 1'b0, wake_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00, rdata_o, osc_trim_o;
  logic src_clk, pin_o, pin_oe, en_io, en_adc, en_cpu, en_flash, core_run;
  int ext_half = 7;
  int err_total = 0;
  int compares = 0;
  localparam logic [7:0] TRIM_SIM = 8'h5a; // arbitrary factory value for the run
  localparam int FAST_SIM = 20; // short start-up spans keep the run brief
  localparam int SLOW_SIM = 40;
  always #2.5 clk_sys_i = ~clk_sys_i;
  // spare oscillators wander at random so the source mux is exercised
  always @(posedge clk_sys_i) begin
    clk_rc_i <= 1'($urandom);
    clk_lp_i <= 1'($urandom);
  end
  scd_ext_clk_model scd_ext_clk_model_inst (.rstn_i(rstn_i), .half_i(ext_half), .clk_o(ext_pin));
  scd_top #(.FACTORY_TRIM(TRIM_SIM), .FAST_CYC(FAST_SIM), .SLOW_CYC(SLOW_SIM)) scd_top_inst (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .ext_clock_in_pin_i(ext_pin), .clk_rc_i(clk_rc_i), .clk_lp_i(clk_lp_i),
    .clock_source_select_fuse_i(src_fuse), .startup_time_fuse_i(sut_fuse), .clock_output_fuse_i(out_fuse),
    .divide_by_eight_fuse_i(div8_fuse), .wake_i(wake_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .src_clk_o(src_clk), .clock_output_pin_o(pin_o),
    .clock_output_pin_oe_o(pin_oe), .clk_en_io_o(en_io), .clk_en_adc_o(en_adc), .clk_en_cpu_o(en_cpu),
    .clk_en_flash_o(en_flash), .core_run_o(core_run), .osc_trim_o(osc_trim_o));
  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // two-step change issued back to back, nothing may slip in between
  task automatic set_div(input logic [3:0] c);
    wr(2'h1, 8'h80);
    wr(2'h1, {4'h0, c});
  endtask
  // shortest start-up span: base cycles plus the fuse-selected time
  function automatic int boot_len(input logic [1:0] startup_time_fuse);
    boot_len = scd_pkg::RESET_BASE_CK;
    if (startup_time_fuse == scd_pkg::SUT_FAST) boot_len = boot_len + FAST_SIM;
    else if (startup_time_fuse != scd_pkg::SUT_BOD) boot_len = boot_len + SLOW_SIM;
  endfunction
  // cycles between two core enable pulses, bounded
  task automatic gap(output int n);
    int i;
    i = 0;
    do begin @(posedge clk_sys_i); #1; i++; end while (en_cpu !== 1'b1 && i < 600);
    n = 0;
    do begin @(posedge clk_sys_i); #1; n++; end while (en_cpu !== 1'b1 && n < 600);
  endtask
  task automatic boot(input logic d8, input logic [1:0] startup_time_fuse, input logic [1:0] src);
    int n;
    logic [7:0] d;
    @(posedge clk_sys_i);
    rstn_i <= 1'b0; div8_fuse <= d8; sut_fuse <= startup_time_fuse; src_fuse <= src;
    // the external boot always programs the output fuse so the pin check bites
    out_fuse <= 1'($urandom) | (src == scd_pkg::SRC_EXT); ext_half <= 5 + $urandom_range(4);
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys_i); #1; n++; end while (core_run !== 1'b1 && n < 200);
    chk(8'(n >= boot_len(startup_time_fuse) && n <= boot_len(startup_time_fuse) + 4), 8'h01);
    rd(2'h0, d);
    chk(d, TRIM_SIM);
    rd(2'h1, d);
    chk(d, d8 ? {4'h0, scd_pkg::DIV_RST_DIV8} : {4'h0, scd_pkg::DIV_RST_NODIV8});
  endtask
  task automatic wrap_up();
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d, t;
    logic [3:0] c;
    int n, k, h;
    void'($urandom(79241));
    boot(1'b1, 2'h1, scd_pkg::SRC_LP);
    boot(1'b0, 2'h2, scd_pkg::SRC_RC);
    boot(1'b0, 2'h0, scd_pkg::SRC_EXT);
    t = 8'($urandom);
    // no memory writes run in this bench, so any trim code is allowed
    wr(2'h0, t);
    rd(2'h0, d);
    chk(d, t);
    wr(2'h3, 8'($urandom));
    rd(2'h3, d);
    chk(d, 8'h00);
    wr(2'h1, 8'h05);
    wr(2'h1, 8'h81);
    wr(2'h1, 8'h02);
    rd(2'h1, d);
    chk(d, 8'h00);
    wr(2'h1, 8'h80);
    rd(2'h1, d);
    chk(d, 8'h80);
    idle4: repeat (4) @(posedge clk_sys_i);
    wr(2'h1, 8'h02);
    rd(2'h1, d);
    chk(d, 8'h00);
    wr(2'h1, 8'h80);
    wr(2'h1, 8'h80);
    // the repeat must leave the bit set, yet the window still ends on time
    rd(2'h1, d);
    chk(d, 8'h80);
    wr(2'h1, 8'h02);
    rd(2'h1, d);
    chk(d, 8'h00);
    c = 4'($urandom_range(15, 9));
    set_div(c);
    rd(2'h1, d);
    chk(d, {4'h0, c});
    for (k = 0; k < 9; k++) begin
      set_div(4'(k));
      rd(2'h1, d);
      chk(d, 8'(k));
      repeat (600) @(posedge clk_sys_i);
      gap(n);
      chk(8'(n == (1 << k)), 8'h01);
      // the pin carries the divided clock: high for half of each divided period
      h = 0;
      repeat (1 << k) begin
        @(posedge clk_sys_i);
        #1;
        h += int'(pin_o);
      end
      chk(8'(h), out_fuse ? 8'(k == 0 ? 1 : 1 << (k - 1)) : 8'h00);
      rd(2'h2, d);
      chk(d, {4'h1, 4'(k)});
    end
    set_div(4'h0);
    repeat (600) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    wake_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_i <= 1'b0;
    // count from the edge that takes the wake request to the first core enable
    n = 0;
    do begin @(posedge clk_sys_i); #1; n++; end while (en_cpu !== 1'b1 && n < 600);
    chk(8'(n >= scd_pkg::WAKE_CK && n <= scd_pkg::WAKE_CK + 3), 8'h01);
    wrap_up();
  end
  // watchdog well beyond the expected run length
  initial begin
    #300000;
    err_total++;
    wrap_up();
  end
endmodule
